/* core/sul_uart.v */
// Serial line core: format, modem control, line and modem status
`timescale 1ns/10ps
`default_nettype none
`include "sul_consts.vh"
module sul_uart (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       register_write_op,
  input  wire       register_read_op,
  output reg  [7:0] reg_rdata,
  output wire       wr_ready,
  output wire       txd,
  input  wire       rxd,
  output wire       rts,
  output wire       dtr,
  output wire       data_rate_select_out,
  output wire       secondary_request_out,
  input  wire       cts,
  input  wire       dsr,
  input  wire       dcd,
  input  wire       ri,
  input  wire       rts_sw,
  input  wire       dtr_sw
);
  reg  [7:0]  fmt_q;
  reg  [4:0]  mctl_q;
  reg  [3:0]  ien_q;
  reg  [15:0] div_q;
  reg  [7:0]  rbuf_q;
  reg         dr_q, oe_q, pe_q, fe_q, bi_q;
  reg  [3:0]  dlt_q;
  reg  [3:0]  msprev_q;
  reg  [7:0]  pre_q;
  reg  [15:0] bdc_q;
  reg         tick16;
  wire        wr = register_write_op;
  wire        rd = register_read_op;
  wire        dlab = fmt_q[`SUL_FMT_DLAB];
  wire        loop = mctl_q[`SUL_MC_LOOP];
  wire [3:0]  dbits = {2'b00, fmt_q[1:0]} + 4'h5;
  function par_of;
    input [7:0] d;
    input [3:0] n;
    input [1:0] s;
    reg         x;
    begin
      x = ^(d & ((8'hFF >> (4'h8 - n))));
      case (s)
        2'b00: par_of = ~x;
        2'b01: par_of = x;
        2'b10: par_of = 1'b1;
        default: par_of = 1'b0;
      endcase
    end
  endfunction
  // 16x tick, one system clock per prescaler count (not the 153600 reference), then divisor
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_q  <= 8'h00;
      bdc_q  <= 16'h0000;
      tick16 <= 1'b0;
    end else begin
      tick16 <= 1'b0;
      if (pre_q >= `SUL_TICK_LAST) begin
        pre_q <= 8'h00;
        if (bdc_q + 16'h0001 >= div_q) begin
          bdc_q  <= 16'h0000;
          tick16 <= 1'b1;
        end else begin
          bdc_q <= bdc_q + 16'h0001;
        end
      end else begin
        pre_q <= pre_q + 8'h01;
      end
    end
  end
  // Transmit path: FIFO holds written characters
  wire [7:0] tf_data;
  wire       tf_valid;
  reg        tf_take;
  wire       thr_wr = wr & ~dlab & (reg_addr == `SUL_ADDR_DATA);
  sul_fifo #(.W(`SUL_FIFO_W), .D(`SUL_FIFO_D), .AW(2)) u_txf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (reg_wdata),
    .in_valid  (thr_wr),
    .in_ready  (wr_ready),
    .out_data  (tf_data),
    .out_valid (tf_valid),
    .out_ready (tf_take)
  );
  // Transmitter: one-hot frame states
  localparam TX_IDLE = 4'b0001, TX_SHIFT = 4'b0010, TX_PAR = 4'b0100, TX_STOP = 4'b1000;
  reg [3:0] tst_q;
  reg [7:0] tsr_q;
  reg [3:0] tcnt_q;
  reg [3:0] tsub_q;
  reg [4:0] tstop_q;
  reg       tpar_q;
  reg       tbit_q;
  always @* begin
    tf_take = (tst_q == TX_IDLE) & tf_valid & tick16;
  end
  // start, data lsb first, parity, stop framing
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tst_q   <= TX_IDLE;
      tsr_q   <= 8'h00;
      tcnt_q  <= 4'h0;
      tsub_q  <= 4'h0;
      tstop_q <= 5'h00;
      tpar_q  <= 1'b0;
      tbit_q  <= 1'b1;
    end else if (tick16) begin
      tsub_q <= tsub_q + 4'h1;
      case (tst_q)
        TX_IDLE: begin
          tbit_q <= 1'b1;
          if (tf_valid) begin
            tsr_q  <= tf_data;
            tpar_q <= par_of(tf_data, dbits, fmt_q[5:4]);
            tbit_q <= 1'b0;
            tcnt_q <= 4'h0;
            // Start cell spans a full 16 ticks
            tsub_q <= 4'h0;
            tst_q  <= TX_SHIFT;
          end
        end
        TX_SHIFT: if (tsub_q == 4'hF) begin
          tbit_q <= tsr_q[0];
          tsr_q  <= {1'b0, tsr_q[7:1]};
          tcnt_q <= tcnt_q + 4'h1;
          if (tcnt_q == dbits) begin
            tbit_q <= fmt_q[`SUL_FMT_PEN] ? tpar_q : 1'b1;
            tst_q  <= fmt_q[`SUL_FMT_PEN] ? TX_PAR : TX_STOP;
            tstop_q <= ~fmt_q[`SUL_FMT_STB] ? 5'd16 : (fmt_q[1:0] == 2'b00) ? 5'd24 : 5'd31;
          end
        end
        TX_PAR: if (tsub_q == 4'hF) begin
          tbit_q <= 1'b1;
          tst_q  <= TX_STOP;
        end
        TX_STOP: begin
          tstop_q <= tstop_q - 5'd1;
          if (tstop_q == 5'd1) tst_q <= TX_IDLE;
        end
        default: tst_q <= TX_IDLE;
      endcase
    end
  end
  // shifter empty when idle, holding empty when FIFO drained
  wire tsr_empty = (tst_q == TX_IDLE);
  wire thr_empty = ~tf_valid;
  // break forces space outside loopback; loopback marks the pin; idle mark
  assign txd = loop ? 1'b1 : (fmt_q[`SUL_FMT_BRK] ? 1'b0 : tbit_q);
  // receiver input from transmitter in loopback
  wire rx_in = loop ? tbit_q : rxd;
  // Receiver with mid-bit sampling
  localparam RX_IDLE = 3'b001, RX_DATA = 3'b010, RX_STOP = 3'b100;
  reg [2:0] rst_q;
  reg [3:0] rsub_q;
  reg [3:0] rcnt_q;
  reg [8:0] rsr_q;
  reg [8:0] spc_q;
  wire [3:0] rlen = dbits + {3'b000, fmt_q[`SUL_FMT_PEN]};
  reg        rx_done, rx_fe, rx_pe, rx_brk;
  reg  [7:0] rx_char;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_q   <= RX_IDLE;
      rsub_q  <= 4'h0;
      rcnt_q  <= 4'h0;
      rsr_q   <= 9'h000;
      spc_q   <= 9'h000;
      rx_done <= 1'b0;
      rx_fe   <= 1'b0;
      rx_pe   <= 1'b0;
      rx_brk  <= 1'b0;
      rx_char <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      rx_brk  <= 1'b0;
      if (tick16) begin
        // count space ticks beyond a full frame
        spc_q <= rx_in ? 9'h000 : (spc_q == 9'h1FF ? spc_q : spc_q + 9'h001);
        if (~rx_in && spc_q == {1'b0, rlen, 4'h0} + 9'h030) rx_brk <= 1'b1;
        case (rst_q)
          RX_IDLE: if (~rx_in) begin
            rsub_q <= rsub_q + 4'h1;
            if (rsub_q == 4'h7) begin
              rsub_q <= 4'h0;
              rcnt_q <= 4'h0;
              rst_q  <= RX_DATA;
            end
          end else begin
            rsub_q <= 4'h0;
          end
          RX_DATA: begin
            rsub_q <= rsub_q + 4'h1;
            if (rsub_q == 4'hF) begin
              rsr_q  <= {rx_in, rsr_q[8:1]};
              rcnt_q <= rcnt_q + 4'h1;
              if (rcnt_q + 4'h1 == rlen) rst_q <= RX_STOP;
            end
          end
          RX_STOP: begin
            rsub_q <= rsub_q + 4'h1;
            if (rsub_q == 4'hF) begin
              rsub_q  <= 4'h0;
              rst_q   <= RX_IDLE;
              rx_done <= 1'b1;
              rx_fe   <= ~rx_in;
              rx_char <= fmt_q[`SUL_FMT_PEN] ? rsr_q[7:0] >> (4'h9 - rlen) : rsr_q[8:1] >> (4'h8 - rlen);
              rx_pe   <= fmt_q[`SUL_FMT_PEN] &
                         (rsr_q[8] != par_of(rsr_q[7:0] >> (4'h9 - rlen), dbits, fmt_q[5:4]));
            end
          end
          default: rst_q <= RX_IDLE;
        endcase
      end
    end
  end
  // loopback maps control outputs onto status inputs
  wire rts_i = mctl_q[1] | rts_sw;
  wire dtr_i = mctl_q[0] | dtr_sw;
  wire [3:0] ms_now = loop ? {mctl_q[3], mctl_q[2], rts_i, dtr_i} : {dcd, ri, dsr, cts};
  // optional outputs; held active by control bits outside loopback, forced inactive in loopback
  assign data_rate_select_out  = ~loop & mctl_q[3];
  assign secondary_request_out = ~loop & mctl_q[2];
  assign rts                   = ~loop & rts_i;
  assign dtr                   = ~loop & dtr_i;
  wire lsr_rd = rd & (reg_addr == `SUL_ADDR_LSTAT);
  wire msr_rd = rd & (reg_addr == `SUL_ADDR_MSTAT);
  wire rbr_rd = rd & ~dlab & (reg_addr == `SUL_ADDR_DATA);
  // change detect uses looped value in loopback
  wire [3:0] chg = ms_now ^ msprev_q;
  // Register writes and status flags; set wins over clear
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fmt_q    <= `SUL_FMT_RST;
      mctl_q   <= 5'h00;
      ien_q    <= 4'h0;
      div_q    <= `SUL_DIV_RST;
      rbuf_q   <= 8'h00;
      dr_q     <= 1'b0;
      oe_q     <= 1'b0;
      pe_q     <= 1'b0;
      fe_q     <= 1'b0;
      bi_q     <= 1'b0;
      dlt_q    <= 4'h0;
      msprev_q <= 4'h0;
    end else begin
      msprev_q <= ms_now;
      if (wr) begin
        case (reg_addr)
          // divisor bytes behind the data and enable slots
          `SUL_ADDR_DATA: if (dlab) div_q[7:0] <= reg_wdata;
          `SUL_ADDR_IEN: if (dlab) div_q[15:8] <= reg_wdata;
                         else ien_q <= reg_wdata[3:0];
          `SUL_ADDR_FMT: fmt_q <= reg_wdata;
          `SUL_ADDR_MCTL: mctl_q <= reg_wdata[4:0];
          default: ;
        endcase
      end
      // line flags clear on line status read
      if (lsr_rd) begin
        oe_q <= 1'b0;
        pe_q <= 1'b0;
        fe_q <= 1'b0;
        bi_q <= 1'b0;
      end
      // clear by buffer read or writing zero
      if (rbr_rd || (wr && reg_addr == `SUL_ADDR_LSTAT && !reg_wdata[0])) dr_q <= 1'b0;
      if (rx_brk) bi_q <= 1'b1;
      if (rx_done) begin
        rbuf_q <= rx_char;
        dr_q   <= 1'b1;
        if (dr_q & ~rbr_rd) oe_q <= 1'b1;
        if (rx_pe) pe_q <= 1'b1;
        if (rx_fe) fe_q <= 1'b1;
      end
      // delta flags, read clears, new change wins
      dlt_q <= (msr_rd ? 4'h0 : dlt_q) |
               {chg[3], chg[2] & msprev_q[2], chg[1], chg[0]};
    end
  end
  // Read mux registered; live levels in upper nibble
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (rd) begin
      case (reg_addr)
        `SUL_ADDR_DATA: reg_rdata <= dlab ? div_q[7:0] : rbuf_q;
        `SUL_ADDR_IEN: reg_rdata <= dlab ? div_q[15:8] : {4'h0, ien_q};
        `SUL_ADDR_FMT: reg_rdata <= fmt_q;
        `SUL_ADDR_MCTL: reg_rdata <= {3'b000, mctl_q};
        `SUL_ADDR_LSTAT: reg_rdata <= {1'b0, tsr_empty & thr_empty, thr_empty,
                                       bi_q, fe_q, pe_q, oe_q, dr_q};
        `SUL_ADDR_MSTAT: reg_rdata <= {ms_now, dlt_q};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

/* core/sul_consts.vh */
// Constants for the serial line and modem control core
// Function
// - Format bit 7 maps slots to divisor
// - Break bit forces output to space outside loopback
// - Parity sense: odd, even, one, zero
// - Parity enable adds and checks parity
// - Stop bits one, one and a half, or two
// - Length code selects five to eight bits
// - Loopback marks output, loops shift registers
// - Loopback feeds control outputs to status
// - Loopback status changes come from outputs
// - Control bits 3, 2 drive optional outputs outside loopback
// - Control bit 1 holds RTS active outside loopback
// - Control bit 0 holds DTR active outside loopback
// - Shifter and holding empty flags
// - Break flag on long space, read clears
// - Framing error on bad stop bit
// - Parity error flag, read clears
// - Overrun flag on overwrite, read clears
// - Data ready cleared by read or zero
// - Status bits 7..4 show line levels
// - Delta flags on change, read clears
// - Ring trailing edge flag, read clears
// - Bit rate is reference over 16 times divisor; here system clock stands in for the reference
// - Low slot low byte, high slot high
`ifndef SUL_CONSTS_VH
`define SUL_CONSTS_VH
`define SUL_ADDR_DATA      8'h11
`define SUL_ADDR_IEN       8'h13
`define SUL_ADDR_FMT       8'h17
`define SUL_ADDR_MCTL      8'h19
`define SUL_ADDR_LSTAT     8'h1B
`define SUL_ADDR_MSTAT     8'h1D
`define SUL_FMT_DLAB       7
`define SUL_FMT_BRK        6
`define SUL_FMT_PEN        3
`define SUL_FMT_STB        2
`define SUL_MC_LOOP        4
`define SUL_FMT_RST        8'h03
`define SUL_DIV_RST        16'h0001
`define SUL_REF_HZ         153600
`define SUL_CLK_HZ         100000000
// Last prescaler count; kept at one clock per 16x tick so a bit cell is
// 16 clocks at divisor one, trading the exact rate for short runs
`define SUL_TICK_LAST      8'h00
`define SUL_FIFO_W         8
`define SUL_FIFO_D         4
`endif

/* core/sul_fifo.v */
// Small synchronous FIFO for transmit characters
`timescale 1ns/10ps
`default_nettype none
module sul_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter AW = 2
) (
  input  wire         clk_sys,
  input  wire         rst,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0]  mem_q [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;
  assign in_ready  = (cnt_q != D);
  assign out_valid = (cnt_q != 0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // Pointers wrap naturally since depth is a power of two
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      if (push & ~pop) cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push) cnt_q <= cnt_q - 1'b1;
    end
  end
  // Storage has no reset; valid count guards it
  always @(posedge clk_sys) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule
`default_nettype wire

/* test/sul_uart_checker.sv */
// Port checker for the serial line core
`timescale 1ns/10ps
`default_nettype none
module sul_uart_checker (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       register_write_op,
  input wire logic       register_read_op,
  input wire logic [7:0] reg_rdata,
  input wire logic       txd,
  input wire logic       rts,
  input wire logic       dtr,
  input wire logic       data_rate_select_out,
  input wire logic       secondary_request_out,
  input wire logic       rts_sw,
  input wire logic       dtr_sw
);
  logic [7:0] fmt_q;
  logic [7:0] mctl_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Shadow of format and control writes, so outputs can be tied to them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fmt_q <= 8'h03;
      mctl_q <= 8'h00;
    end else if (register_write_op && reg_addr == 8'h17) begin
      fmt_q <= reg_wdata;
    end else if (register_write_op && reg_addr == 8'h19) begin
      mctl_q <= reg_wdata;
    end
  end
  property p_brk; fmt_q[6] && !mctl_q[4] |-> !txd; endproperty
  a_brk: assert property (p_brk) else $error("txd not at space in break");
  property p_loop_mark; mctl_q[4] && !fmt_q[6] |-> txd; endproperty
  a_loop_mark: assert property (p_loop_mark) else $error("txd not at mark in loop");
  property p_loop_outs; mctl_q[4] |-> !(rts | dtr | data_rate_select_out); endproperty
  a_loop_outs: assert property (p_loop_outs) else $error("outputs active in loop");
  property p_opt;
    !mctl_q[4] |-> data_rate_select_out == mctl_q[3] && secondary_request_out == mctl_q[2];
  endproperty
  a_opt: assert property (p_opt) else $error("optional outputs wrong");
  property p_rts; !mctl_q[4] |-> rts == (mctl_q[1] | rts_sw); endproperty
  a_rts: assert property (p_rts) else $error("rts wrong");
  property p_dtr; !mctl_q[4] |-> dtr == (mctl_q[0] | dtr_sw); endproperty
  a_dtr: assert property (p_dtr) else $error("dtr wrong");
  property p_rd_fmt; register_read_op && reg_addr == 8'h17 |=> reg_rdata == $past(fmt_q); endproperty
  a_rd_fmt: assert property (p_rd_fmt) else $error("format readback wrong");
  // Every bit cell lasts at least 16 cycles, so a start bit holds low
  property p_start; $fell(txd) && !fmt_q[6] && !mctl_q[4] |-> !txd [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
endmodule
bind sul_uart sul_uart_checker u_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .register_write_op(register_write_op), .register_read_op(register_read_op),
  .reg_rdata(reg_rdata), .txd(txd), .rts(rts), .dtr(dtr),
  .data_rate_select_out(data_rate_select_out),
  .secondary_request_out(secondary_request_out), .rts_sw(rts_sw), .dtr_sw(dtr_sw)
);
`default_nettype wire

/* test/sul_peer.sv */
// Far-side serial peer: sends frames on rxd, captures frames from txd
`timescale 1ns/10ps
`default_nettype none
module sul_peer (
  input  wire logic clk_sys,
  input  wire logic txd,
  output var  logic rxd
);
  initial rxd = 1'b1;
  task automatic send(input logic [8:0] w, input int nb, input logic s);
    rxd <= 1'b0;
    repeat (16) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      rxd <= w[i];
      repeat (16) @(posedge clk_sys);
    end
    rxd <= s;
    repeat (16) @(posedge clk_sys);
    rxd <= 1'b1;
    @(posedge clk_sys);
  endtask
  // Long space, as a line break
  task automatic space(input int c);
    rxd <= 1'b0;
    repeat (c) @(posedge clk_sys);
    rxd <= 1'b1;
  endtask
  task automatic get(input int nb, output logic [8:0] w, output logic s);
    int i;
    w = 9'h000;
    i = 0;
    while (txd !== 1'b0 && i < 4000) begin
      @(posedge clk_sys);
      i++;
    end
    repeat (8) @(posedge clk_sys);
    for (i = 0; i < nb; i++) begin
      repeat (16) @(posedge clk_sys);
      w[i] = txd;
    end
    repeat (16) @(posedge clk_sys);
    s = txd;
  endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the serial line core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       clk_sys, rst, register_write_op, register_read_op, wr_ready, txd, rxd;
  logic       rts, dtr, data_rate_select_out, secondary_request_out, rts_sw, dtr_sw;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] mdm;
  int         fail_count, tests_run, cyc;
  sul_uart u_dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .register_write_op(register_write_op), .register_read_op(register_read_op),
    .reg_rdata(reg_rdata), .wr_ready(wr_ready), .txd(txd), .rxd(rxd), .rts(rts),
    .dtr(dtr), .data_rate_select_out(data_rate_select_out),
    .secondary_request_out(secondary_request_out), .cts(mdm[0]), .dsr(mdm[1]),
    .dcd(mdm[3]), .ri(mdm[2]), .rts_sw(rts_sw), .dtr_sw(dtr_sw)
  );
  sul_peer u_peer (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    register_write_op <= 1'b1;
    @(posedge clk_sys);
    register_write_op <= 1'b0;
  endtask
  // Read data is registered, so it is looked at after the taking edge
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    register_read_op <= 1'b1;
    @(posedge clk_sys);
    register_read_op <= 1'b0;
    #1 chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, reg_rdata & m});
  endtask
  function automatic logic par(input logic [8:0] v, input logic [1:0] ps);
    case (ps)
      2'b00: return ~^v;
      2'b01: return ^v;
      2'b10: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    logic [7:0] d, msk;
    logic [8:0] w, e;
    logic [3:0] v, o;
    logic       s, pen, bad;
    int         n, k;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    register_write_op = 1'b0;
    register_read_op = 1'b0;
    mdm = 4'h0;
    rts_sw = 1'b0;
    dtr_sw = 1'b0;
    void'($urandom(32'h01d6ee93));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rc(8'h17, 8'hFF, 8'h03);
    rc(8'h1B, 8'h61, 8'h60);
    rc(8'h20, 8'hFF, 8'h00);
    wr(8'h17, 8'h83);
    wr(8'h11, 8'h34);
    wr(8'h13, 8'h12);
    rc(8'h11, 8'hFF, 8'h34);
    rc(8'h13, 8'hFF, 8'h12);
    wr(8'h11, 8'h01);
    wr(8'h13, 8'h00);
    // Every length and parity sense, out and back, with errors injected
    for (k = 0; k < 20; k++) begin
      n = 5 + k % 4;
      pen = (k < 16);
      bad = pen && (k % 3 == 0);
      d = $urandom;
      rts_sw <= $urandom;
      dtr_sw <= $urandom;
      wr(8'h17, {2'b00, k[3:2], pen, 1'($urandom), k[1:0]});
      msk = 8'((9'h001 << n) - 9'h001);
      e = {1'b0, d & msk};
      if (pen) e[n] = par(e, k[3:2]);
      fork
        wr(8'h11, d);
        u_peer.get(n + pen, w, s);
      join
      chk("tx frame", e, w);
      chk("tx stop", 9'h001, {8'h00, s});
      if (bad) e[n] = ~e[n];
      u_peer.send(e, n + pen, k != 19);
      repeat (20) @(posedge clk_sys);
      rc(8'h1B, 8'h0F, {4'h0, k == 19, bad, 2'b01});
      rc(8'h11, msk, d & msk);
      rc(8'h1B, 8'h0F, 8'h00);
    end
    // Cut stop bit may start a false frame; let it finish and flush it
    rts_sw <= 1'b0;
    dtr_sw <= 1'b0;
    repeat (200) @(posedge clk_sys);
    rc(8'h11, 8'h00, 8'h00);
    rc(8'h1B, 8'h00, 8'h00);
    wr(8'h17, 8'h03);
    u_peer.send(9'h0A5, 8, 1'b1);
    u_peer.send(9'h03C, 8, 1'b1);
    repeat (20) @(posedge clk_sys);
    rc(8'h1B, 8'h03, 8'h03);
    rc(8'h1B, 8'h03, 8'h01);
    rc(8'h11, 8'hFF, 8'h3C);
    u_peer.space(400);
    repeat (20) @(posedge clk_sys);
    rc(8'h1B, 8'h11, 8'h11);
    wr(8'h1B, 8'h00);
    rc(8'h1B, 8'h11, 8'h00);
    // Frames started inside the long space still complete; flush them
    repeat (200) @(posedge clk_sys);
    rc(8'h11, 8'h00, 8'h00);
    rc(8'h1B, 8'h00, 8'h00);
    wr(8'h17, 8'h43);
    repeat (40) @(posedge clk_sys);
    chk("txd", 9'h000, {8'h00, txd});
    wr(8'h17, 8'h03);
    #1 chk("txd", 9'h001, {8'h00, txd});
    // Fill the transmit queue until it refuses, then let it drain
    k = 0;
    while (wr_ready === 1'b1 && k < 8) begin
      wr(8'h11, 8'(k));
      #1 k++;
    end
    chk("wr_ready", 9'h000, {8'h00, wr_ready});
    rc(8'h1B, 8'h60, 8'h00);
    repeat (1200) @(posedge clk_sys);
    rc(8'h1B, 8'h60, 8'h60);
    for (k = 0; k < 6; k++) begin
      v = (k == 0) ? 4'hF : (k == 1) ? 4'h0 : 4'($urandom);
      o = mdm;
      mdm <= v;
      repeat (4) @(posedge clk_sys);
      rc(8'h1D, 8'hFF, {v, ((v ^ o) & 4'hB) | (o & ~v & 4'h4)});
      rc(8'h1D, 8'h0F, 8'h00);
    end
    for (k = 0; k < 4; k++) begin
      v = 4'($urandom);
      mdm <= ~v;
      wr(8'h19, {4'h1, v});
      repeat (4) @(posedge clk_sys);
      rc(8'h1D, 8'hF0, {v, 4'h0});
    end
    wr(8'h19, 8'h10);
    rc(8'h1D, 8'hF0, 8'h00);
    wr(8'h19, 8'h19);
    repeat (4) @(posedge clk_sys);
    rc(8'h1D, 8'hFF, 8'h99);
    d = $urandom;
    fork
      wr(8'h11, d);
      u_peer.space(250);
    join
    repeat (100) @(posedge clk_sys);
    rc(8'h1B, 8'h1F, 8'h01);
    rc(8'h11, 8'hFF, d);
    wr(8'h19, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
